/* File: src/ccx_exec.sv */
// Execution unit for call, file clear, watchdog kick, file invert and
// equal-compare-skip. Assumes the fetch unit holds instr_i stable for a
// whole four-phase cycle and presents the call's second word in cycle two.
`timescale 1ns/1ps

// Behaviour
// RULE_01: Call pushes call address plus four onto return stack top first.
// RULE_02: Call loads literal into PC bits 20..1, bit 0 zero, two cycles.
// RULE_03: Fast call copies working, status and bank into their shadows.
// RULE_04: Non-fast call leaves shadows untouched; call changes no flags.
// RULE_05: File clear writes zero to the register and sets zero flag only.
// RULE_06: Access bit one selects the bank named by bank select.
// RULE_07: Access bit zero selects the fixed access bank.
// RULE_08: Watchdog kick zeroes counter and prescaler, sets expiry and sleep flags.
// RULE_09: Watchdog kick leaves the postscaler assignment alone.
// RULE_10: Invert complements the register, updating only zero and negative.
// RULE_11: Destination zero writes working register, one writes back to file.
// RULE_12: Equal compare subtracts unsigned, changing no flag or operand.
// RULE_13: Equal result discards next instruction: two cycles, three if two-word.
// RULE_14: One cycle is four phases; compare and kick have no write-back.
module ccx_exec
(
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  sys_rst_i,
  // Instruction stream
  input  wire logic [15:0]           instr_i,
  input  wire logic [20:0]           pc_i,
  // Data memory
  input  wire logic [7:0]            file_rdata_i,
  output logic      [11:0]           file_raddr_o,
  output ccx_pkg::ccx_dwr_t          file_wr_o,
  // Core state
  output ccx_pkg::ccx_ctx_t          ctx_o,
  output ccx_pkg::ccx_ctx_t          shadow_o,
  output logic      [20:0]           pc_o,
  output logic                       pc_load_o,
  output logic      [20:0]           return_stack_top_o,
  output logic                       stack_push_o,
  // Watchdog
  output logic                       watchdog_clear_o,
  input  wire logic                  postscale_sel_i,
  output logic                       postscale_sel_o,
  // Sequencing
  output ccx_pkg::ccx_phase_t        phase_o,
  output logic                       cycle_end_o,
  output logic                       busy_o
);

  ccx_pkg::ccx_phase_t phase_q;
  ccx_pkg::ccx_cycle_t cyc_q;
  ccx_pkg::ccx_ctx_t   ctx_q;
  ccx_pkg::ccx_ctx_t   shadow_q;
  ccx_pkg::ccx_dwr_t   wr_q;
  logic [7:0]          operand_q;
  logic [7:0]          result_q;
  logic [19:0]         call_lit_q;
  logic                call_fast_q;
  logic [20:0]         call_pc_q;
  logic [20:0]         tos_q;
  logic                push_q;
  logic [20:0]         pc_q;
  logic                pc_load_q;
  logic                wd_clr_q;
  logic                match_q;
  logic [11:0]         addr_w;

  logic is_zero;
  logic is_inv;
  logic is_cmp;
  logic is_call;
  logic is_kick;
  logic exec;

  function automatic logic two_word(input logic [15:0] w);
    two_word = (w[15:9] == ccx_pkg::OPC_CALL) || (w[15:12] == 4'hc);
  endfunction

  assign exec    = (cyc_q == ccx_pkg::CCX_C_EXEC);
  assign is_zero = exec && (instr_i[15:9] == ccx_pkg::OPC_FILE_ZERO);
  assign is_inv  = exec && (instr_i[15:10] == ccx_pkg::OPC_FILE_INVERT);
  assign is_cmp  = exec && (instr_i[15:9] == ccx_pkg::OPC_EQ_SKIP);
  assign is_call = exec && (instr_i[15:9] == ccx_pkg::OPC_CALL);
  assign is_kick = exec && (instr_i == ccx_pkg::OPC_WDOG_KICK);

  ccx_addr_gen u_addr
  (
    .file_addr_i       (instr_i[7:0]),
    .access_bit_i      (instr_i[8]),
    .bank_select_reg_i (ctx_q.bank),
    .data_addr_o       (addr_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Four-phase sequencer

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      phase_q <= ccx_pkg::CCX_Q_DECODE;
    else
      phase_q <= ccx_pkg::ccx_phase_t'(phase_q + 2'b01); // RULE_14
  end

  // Cycle kind advances only at the end of the write-back phase
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cyc_q <= ccx_pkg::CCX_C_EXEC;
    else if (phase_q == ccx_pkg::CCX_Q_WRITE)
    begin
      case (cyc_q)
        ccx_pkg::CCX_C_EXEC:
        begin
          if (is_call)
            cyc_q <= ccx_pkg::CCX_C_IDLE; // RULE_02
          else if (is_cmp && match_q)
            cyc_q <= ccx_pkg::CCX_C_SKIP1; // RULE_13
        end
        ccx_pkg::CCX_C_SKIP1:
        begin
          // The discarded word is on instr_i now; a two-word one costs one more
          if (two_word(instr_i))
            cyc_q <= ccx_pkg::CCX_C_SKIP2; // RULE_13
          else
            cyc_q <= ccx_pkg::CCX_C_EXEC;
        end
        ccx_pkg::CCX_C_IDLE:  cyc_q <= ccx_pkg::CCX_C_EXEC;
        ccx_pkg::CCX_C_SKIP2: cyc_q <= ccx_pkg::CCX_C_EXEC;
        default:              cyc_q <= ccx_pkg::CCX_C_EXEC;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand read and processing

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      operand_q <= ccx_pkg::ZERO_BYTE;
      result_q  <= ccx_pkg::ZERO_BYTE;
      match_q   <= 1'b0;
    end
    else if (phase_q == ccx_pkg::CCX_Q_READ)
      operand_q <= file_rdata_i;
    else if (phase_q == ccx_pkg::CCX_Q_PROCESS)
    begin
      result_q <= is_zero ? ccx_pkg::ZERO_BYTE : ~operand_q; // RULE_05 RULE_10
      match_q  <= ((operand_q - ctx_q.working) == ccx_pkg::ZERO_BYTE); // RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-back: data memory, working register, status

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      wr_q <= '0;
    else if ((phase_q == ccx_pkg::CCX_Q_PROCESS) && (is_zero || (is_inv && instr_i[9])))
    begin
      wr_q.wr   <= 1'b1; // RULE_11
      wr_q.addr <= addr_w;
      wr_q.data <= is_zero ? ccx_pkg::ZERO_BYTE : ~operand_q; // RULE_05
    end
    else
      wr_q.wr <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctx_q.working <= ccx_pkg::ZERO_BYTE;
      ctx_q.status  <= ccx_pkg::STATUS_RST;
      ctx_q.bank    <= 4'h0;
    end
    else if (phase_q == ccx_pkg::CCX_Q_WRITE)
    begin
      if (is_zero)
        ctx_q.status[ccx_pkg::ST_Z] <= 1'b1; // RULE_05
      if (is_inv)
      begin
        ctx_q.status[ccx_pkg::ST_Z] <= (result_q == ccx_pkg::ZERO_BYTE); // RULE_10
        ctx_q.status[ccx_pkg::ST_N] <= result_q[7];
        if (!instr_i[9])
          ctx_q.working <= result_q; // RULE_11
      end
      if (is_kick)
      begin
        ctx_q.status[ccx_pkg::ST_TO] <= 1'b1; // RULE_08
        ctx_q.status[ccx_pkg::ST_PD] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Call: stack push, shadow save, program counter load

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      call_lit_q  <= 20'h00000;
      call_fast_q <= 1'b0;
      call_pc_q   <= 21'h000000;
    end
    else if (is_call && (phase_q == ccx_pkg::CCX_Q_READ))
    begin
      call_lit_q[7:0] <= instr_i[7:0];
      call_fast_q     <= instr_i[8];
      call_pc_q       <= pc_i;
    end
    else if ((cyc_q == ccx_pkg::CCX_C_IDLE) && (phase_q == ccx_pkg::CCX_Q_READ))
      call_lit_q[19:8] <= instr_i[11:0];
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tos_q  <= 21'h000000;
      push_q <= 1'b0;
    end
    else if (is_call && (phase_q == ccx_pkg::CCX_Q_PROCESS))
    begin
      tos_q  <= call_pc_q + ccx_pkg::CALL_RET_OFS; // RULE_01
      push_q <= 1'b1;
    end
    else
      push_q <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      shadow_q <= '0;
    else if (is_call && call_fast_q && (phase_q == ccx_pkg::CCX_Q_PROCESS))
      shadow_q <= ctx_q; // RULE_03 RULE_04
  end

  // PC loads late in the idle cycle, after the push has gone out
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pc_q      <= 21'h000000;
      pc_load_q <= 1'b0;
    end
    else if ((cyc_q == ccx_pkg::CCX_C_IDLE) && (phase_q == ccx_pkg::CCX_Q_PROCESS))
    begin
      pc_q      <= {call_lit_q, 1'b0}; // RULE_02
      pc_load_q <= 1'b1;
    end
    else
      pc_load_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog kick

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      wd_clr_q <= 1'b0;
    else
      wd_clr_q <= is_kick && (phase_q == ccx_pkg::CCX_Q_PROCESS); // RULE_08
  end

  assign postscale_sel_o    = postscale_sel_i; // RULE_09
  assign watchdog_clear_o   = wd_clr_q;
  assign file_raddr_o       = addr_w;
  assign file_wr_o          = wr_q;
  assign ctx_o              = ctx_q;
  assign shadow_o           = shadow_q;
  assign pc_o               = pc_q;
  assign pc_load_o          = pc_load_q;
  assign return_stack_top_o = tos_q;
  assign stack_push_o       = push_q;
  assign phase_o            = phase_q;
  assign cycle_end_o        = (phase_q == ccx_pkg::CCX_Q_WRITE);
  assign busy_o             = (cyc_q != ccx_pkg::CCX_C_EXEC);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_push_before_pc: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_01
    stack_push_o |-> ##4 pc_load_o)
    else $error("call push not followed by pc load");

  chk_call_pc_even: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_02
    pc_load_o |-> (pc_o[0] == 1'b0) && (return_stack_top_o == $past(tos_q, 1)))
    else $error("call target odd or stack top moved");

  chk_shadow_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_04
    !(is_call && call_fast_q) |=> $stable(shadow_q))
    else $error("shadow changed without fast call");

  chk_zero_writes: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_05
    (is_zero && phase_q == ccx_pkg::CCX_Q_PROCESS) |=> file_wr_o.wr && file_wr_o.data == 8'h00)
    else $error("file clear did not write zero");

  chk_kick_flags: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_08
    (is_kick && phase_q == ccx_pkg::CCX_Q_WRITE) |=> ctx_q.status[1:0] == 2'b11)
    else $error("kick did not set expiry and sleep flags");

  chk_cmp_no_flags: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_12
    (is_cmp || is_call) |=> $stable(ctx_q.status))
    else $error("compare or call changed status");

  chk_skip_length: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_13
    (cyc_q == ccx_pkg::CCX_C_SKIP1 && phase_q == ccx_pkg::CCX_Q_DECODE) |-> ##4 busy_o == two_word(instr_i))
    else $error("skip length wrong");

  chk_no_wb_cmp: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_14
    (is_cmp || is_kick) |=> !file_wr_o.wr)
    else $error("compare or kick wrote data memory");

  cov_fast_call: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    is_call && call_fast_q && phase_q == ccx_pkg::CCX_Q_PROCESS);
  cov_skip2: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cyc_q == ccx_pkg::CCX_C_SKIP2);
  cov_invert_w: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    is_inv && !instr_i[9] && phase_q == ccx_pkg::CCX_Q_WRITE);

endmodule

/* File: common/ccx_pkg.sv */
// Package for the call/clear/compare execution block.
// Assumes a 21-bit program counter, 12-bit data addresses and 8-bit data.
package ccx_pkg;

  localparam int unsigned PC_W         = 21;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned DADDR_W      = 12;
  localparam logic [20:0] CALL_RET_OFS = 21'h000004;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [3:0]  ACCESS_BANK  = 4'h0;

  // Opcode fields of the first instruction word and the second-word prefix
  localparam logic [6:0]  OPC_FILE_ZERO   = 7'h35;
  localparam logic [6:0]  OPC_EQ_SKIP     = 7'h31;
  localparam logic [5:0]  OPC_FILE_INVERT = 6'h07;
  localparam logic [6:0]  OPC_CALL        = 7'h76;
  localparam logic [15:0] OPC_WDOG_KICK   = 16'h0004;
  localparam logic [3:0]  OPC_SECOND_WORD = 4'hf;

  // Status bit positions and reset value
  localparam int unsigned ST_N  = 4;
  localparam int unsigned ST_Z  = 2;
  localparam int unsigned ST_PD = 1;
  localparam int unsigned ST_TO = 0;
  localparam logic [7:0]  STATUS_RST = 8'h03;

  typedef enum logic [1:0] {
    CCX_Q_DECODE  = 2'b00,
    CCX_Q_READ    = 2'b01,
    CCX_Q_PROCESS = 2'b10,
    CCX_Q_WRITE   = 2'b11
  } ccx_phase_t;

  typedef enum logic [1:0] {
    CCX_C_EXEC  = 2'b00,
    CCX_C_IDLE  = 2'b01,
    CCX_C_SKIP1 = 2'b10,
    CCX_C_SKIP2 = 2'b11
  } ccx_cycle_t;

  typedef struct packed {
    logic [7:0] working;
    logic [7:0] status;
    logic [3:0] bank;
  } ccx_ctx_t;

  typedef struct packed {
    logic               wr;
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } ccx_dwr_t;

endpackage

/* File: src/ccx_addr_gen.sv */
// File-register address former for the execution block.
// Assumes a 4-bit bank select and the fixed access bank at bank zero.
`timescale 1ns/1ps

module ccx_addr_gen
(
  // Instruction fields
  input  wire logic [7:0]  file_addr_i,
  input  wire logic        access_bit_i,
  // Bank state
  input  wire logic [3:0]  bank_select_reg_i,
  // Full data address
  output logic      [11:0] data_addr_o
);

  always_comb
  begin
    if (access_bit_i)
      data_addr_o = {bank_select_reg_i, file_addr_i}; // RULE_06
    else
      data_addr_o = {ccx_pkg::ACCESS_BANK, file_addr_i}; // RULE_07
  end

endmodule

/* File: test/ccx_dmem_model.sv */
// Behavioural banked data memory facing the execution block.
// Assumes one write port registered on the clock and a combinational read.
`timescale 1ns/1ps

module ccx_dmem_model
(
  // Clock
  input  wire logic              sys_clk_i,
  // Access from the execution block
  input  wire logic [11:0]       raddr_i,
  input  wire ccx_pkg::ccx_dwr_t wr_i,
  output logic      [7:0]        rdata_o
);
  logic [7:0] mem [0:4095];

  // Read follows the address at once, as the core expects in its read phase
  assign rdata_o = mem[raddr_i];

  always @(posedge sys_clk_i)
  begin
    if (wr_i.wr)
      mem[wr_i.addr] <= wr_i.data;
  end

  task automatic poke(input logic [11:0] a, input logic [7:0] v);
    mem[a] = v;
  endtask

  // Fill non-zero except where the low address byte is 5a, so that a clear is visible
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = i[7:0] ^ 8'h5a;
  end
endmodule

/* File: test/ccx_exec_test.sv */
// Self-checking bench for the call/clear/compare execution block.
// Assumes phase zero holds through reset and ends at the first edge after reset release.
`timescale 1ns/1ps

module ccx_exec_test;
  logic                sys_clk_i;
  logic                sys_rst_i;
  logic [15:0]         instr_i;
  logic [20:0]         pc_i;
  logic [7:0]          file_rdata_i;
  logic [11:0]         file_raddr_o;
  ccx_pkg::ccx_dwr_t   file_wr_o;
  ccx_pkg::ccx_ctx_t   ctx_o;
  ccx_pkg::ccx_ctx_t   shadow_o;
  logic [20:0]         pc_o;
  logic                pc_load_o;
  logic [20:0]         return_stack_top_o;
  logic                stack_push_o;
  logic                watchdog_clear_o;
  logic                postscale_sel_i;
  logic                postscale_sel_o;
  ccx_pkg::ccx_phase_t phase_o;
  logic                cycle_end_o;
  logic                busy_o;
  int                  mismatches;
  int                  checks_done;
  int                  pushes;
  int                  loads;
  int                  kicks;
  int                  writes;
  logic [11:0]         wr_addr;
  logic [7:0]          wr_data;
  ccx_pkg::ccx_ctx_t   saved;

  ccx_exec u_ccx_exec (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
    .pc_i(pc_i), .file_rdata_i(file_rdata_i), .file_raddr_o(file_raddr_o),
    .file_wr_o(file_wr_o), .ctx_o(ctx_o), .shadow_o(shadow_o), .pc_o(pc_o),
    .pc_load_o(pc_load_o), .return_stack_top_o(return_stack_top_o),
    .stack_push_o(stack_push_o), .watchdog_clear_o(watchdog_clear_o),
    .postscale_sel_i(postscale_sel_i), .postscale_sel_o(postscale_sel_o),
    .phase_o(phase_o), .cycle_end_o(cycle_end_o), .busy_o(busy_o));

  ccx_dmem_model u_ccx_dmem_model (.sys_clk_i(sys_clk_i), .raddr_i(file_raddr_o),
    .wr_i(file_wr_o), .rdata_o(file_rdata_i));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Pulses last one clock, so they are counted mid-cycle
  always @(negedge sys_clk_i)
  begin
    if (stack_push_o === 1'b1) pushes++;
    if (pc_load_o === 1'b1) loads++;
    if (watchdog_clear_o === 1'b1) kicks++;
    if (file_wr_o.wr === 1'b1)
    begin
      writes++;
      wr_addr = file_wr_o.addr;
      wr_data = file_wr_o.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Word goes out one edge into decode, so it still stands at the write-back
  // edge; returns just after that edge, when the context has been updated
  task automatic op(input logic [15:0] w, input logic [20:0] p = 21'h000000);
    @(posedge sys_clk_i);
    instr_i <= w;
    pc_i    <= p;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    mismatches++;
    end_of_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst_i = 1'b1;
    instr_i = 16'h0000;
    pc_i = 21'h000000;
    postscale_sel_i = 1'b1;
    mismatches = 0;
    checks_done = 0;
    pushes = 0;
    loads = 0;
    kicks = 0;
    writes = 0;
    u_ccx_dmem_model.poke(12'h012, 8'h13);
    u_ccx_dmem_model.poke(12'h020, 8'hec);
    u_ccx_dmem_model.poke(12'h021, 8'h77);
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    op({ccx_pkg::OPC_FILE_INVERT, 1'b1, 1'b1, 8'h55});
    check(wr_data, 8'hf0);
    check(wr_addr, 12'h055);
    check(ctx_o.status, 8'h13);
    op({ccx_pkg::OPC_FILE_INVERT, 1'b0, 1'b0, 8'h12});
    check(ctx_o.working, 8'hec);
    check(writes, 1);
    check(ctx_o.status, 8'h13);
    op({ccx_pkg::OPC_FILE_ZERO, 1'b0, 8'h40});
    check({wr_addr, wr_data}, {ccx_pkg::ACCESS_BANK, 8'h40, 8'h00});
    check(ctx_o.status, 8'h17);
    // Unequal compare lets the next instruction run
    op({ccx_pkg::OPC_EQ_SKIP, 1'b0, 8'h21});
    check({writes, ctx_o.status, ctx_o.working}, {32'd2, 8'h17, 8'hec});
    op({ccx_pkg::OPC_FILE_ZERO, 1'b0, 8'h30});
    check({writes, busy_o}, {32'd3, 1'b0});
    // Equal compare swallows one word, then a two-word call
    op({ccx_pkg::OPC_EQ_SKIP, 1'b1, 8'h20});
    check({writes, ctx_o.status}, {32'd3, 8'h17});
    op({ccx_pkg::OPC_FILE_ZERO, 1'b0, 8'h21});
    check({writes, busy_o}, {32'd3, 1'b0});
    op({ccx_pkg::OPC_EQ_SKIP, 1'b0, 8'h20});
    op({ccx_pkg::OPC_CALL, 1'b1, 8'h11}, 21'h000200);
    check(busy_o, 1'b1);
    op({ccx_pkg::OPC_SECOND_WORD, 12'h222});
    check({busy_o, pushes[7:0], loads[7:0]}, {1'b0, 8'd0, 8'd0});
    op(ccx_pkg::OPC_WDOG_KICK);
    check({kicks, writes}, {32'd1, 32'd3});
    check({ctx_o.status[1:0], postscale_sel_o}, 3'b111);
    // Fast call, then a plain call after the context moved on
    saved = ctx_o;
    op({ccx_pkg::OPC_CALL, 1'b1, 8'hde}, 21'h001000);
    check({pushes, loads}, {32'd1, 32'd0});
    check(return_stack_top_o, 21'h001004);
    op({ccx_pkg::OPC_SECOND_WORD, 12'habc});
    check({loads, pc_o}, {32'd1, 20'habcde, 1'b0});
    check(shadow_o, saved);
    check(ctx_o, saved);
    op({ccx_pkg::OPC_FILE_INVERT, 1'b0, 1'b0, 8'h30});
    check(ctx_o.working, 8'hff);
    op({ccx_pkg::OPC_CALL, 1'b0, 8'h00}, 21'h1ffffc);
    check(return_stack_top_o, 21'h000000);
    op({ccx_pkg::OPC_SECOND_WORD, 12'h001});
    check({loads, pc_o}, {32'd2, 21'h000200});
    check(shadow_o, saved);
    end_of_test;
  end
endmodule
